/* File: rtl/element_classifier.v */
// Purpose: Identify a gather-list element from its flag byte
// Assumes: Pure combinational, same clock domain as caller
// Notes: Buffer tag size is 0, 4, 8 or 12 bytes
`timescale 1ns/100ps
`include "sgl_decoder_defines.vh"
module element_classifier (
  // Flag byte
  input wire [7:0] i_flags,
  // Decoded kind and sizes
  output wire o_is_long,
  output wire o_is_short,
  output wire o_is_page,
  output wire o_is_attr,
  output wire o_is_ignore,
  output wire o_last,
  output wire [31:0] o_tag_bytes
);
  assign o_is_long = (i_flags[6:2] == `CODE_LONG);
  assign o_is_short = (i_flags[6:2] == `CODE_SHORT);
  assign o_is_page = (i_flags[5:4] == `CODE_PAGE);
  assign o_is_attr = (i_flags[6:0] == `CODE_ATTR);
  assign o_is_ignore = (i_flags[6:0] == `CODE_IGNORE);
  assign o_last = i_flags[7];
  // Tag size select counts whole words
  assign o_tag_bytes = {28'h000_0000, i_flags[1:0], 2'h0};
endmodule // element_classifier

/* File: rtl/page_span_calc.v */
// Purpose: Page count and data end for a page-list element
// Assumes: Page size is a power of two
// Notes: End address is one past the last data byte
`timescale 1ns/100ps
module page_span_calc (
  // Element values
  input wire [31:0] i_first_pointer,
  input wire [31:0] i_total_octets,
  input wire [31:0] i_page_size,
  input wire [31:0] i_last_base,
  // Results
  output wire [31:0] o_page_count,
  output wire [31:0] o_data_end
);
  // Shift amount for a power-of-two page size
  function [4:0] log2_of;
    input [31:0] value;
    integer k;
    begin
      log2_of = 5'h00;
      for (k = 0; k < 32; k = k + 1)
      begin
        if (value[k])
          log2_of = k[4:0];
      end
    end
  endfunction
  wire [4:0] shift = log2_of(i_page_size);
  wire [31:0] offset = i_first_pointer & (i_page_size - 32'h0000_0001);
  wire [31:0] span = offset + i_total_octets + i_page_size - 32'h0000_0001;
  wire [31:0] first_part = i_page_size - offset;
  wire [31:0] middle_part = (o_page_count - 32'h0000_0002) << shift;
  assign o_page_count = (i_total_octets == 32'h0000_0000) ? 32'h0000_0001 : (span >> shift);
  assign o_data_end = (o_page_count == 32'h0000_0001) ? (i_first_pointer + i_total_octets) :
    (i_last_base + (i_total_octets - first_part - middle_part));
endmodule // page_span_calc

/* File: rtl/sgl_element_decoder.v */
// Purpose: Walk a gather list held in local memory and decode each element
// Assumes: Classic Wishbone slave, one clock, synchronous active-low reset
// Notes: Software fills the list window, then writes the start bit
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "sgl_decoder_defines.vh"
module sgl_element_decoder (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Decode activity
  output wire o_busy,
  output reg o_element_strobe,
  output reg [7:0] o_element_flags
);
  // ****************************************
  // Walk states
  // ****************************************
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_HEAD = 4'b0010;
  localparam [3:0] S_PAGE = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;

  // Byte address to memory index
  function [`LIST_INDEX_BITS-1:0] word_index;
    input [31:0] byte_addr;
    begin
      word_index = byte_addr[`LIST_INDEX_BITS+1:2];
    end
  endfunction

  // Byte address still inside the list window
  function in_window;
    input [31:0] byte_addr;
    begin
      in_window = (byte_addr[31:2] < `LIST_WORDS);
    end
  endfunction

  // Apply byte lanes of a write
  function [31:0] lane_merge;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] sel;
    integer b;
    begin
      lane_merge = old_value;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (sel[b])
          lane_merge[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [31:0] list_mem [0:`LIST_WORDS-1];
  reg [3:0] state;
  reg [31:0] pointer;
  reg [6:0] status;
  reg [31:0] default_page;
  reg [31:0] default_attr;
  reg [31:0] elem_count;
  reg [31:0] tag_low;
  reg [31:0] tag_high;
  reg [31:0] data_end;
  reg [31:0] eff_page;
  reg [15:0] eff_attr;
  reg only_ignored;
  reg [31:0] page_first;
  reg [31:0] page_total;
  reg [31:0] page_tag;
  reg page_last;
  integer i;

  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_write = bus_req & i_wb_we;
  wire start = bus_write & (i_wb_adr == `REG_CONTROL) & i_wb_sel[0] & i_wb_dat[0];
  wire mem_hit = (i_wb_adr >= `REG_LIST_BASE);
  wire [`LIST_INDEX_BITS-1:0] bus_index = i_wb_adr[`LIST_INDEX_BITS+1:2];
  assign o_busy = status[`ST_BUSY];

  // ****************************************
  // Current element fields
  // ****************************************
  wire [31:0] head = list_mem[word_index(pointer)];
  wire [31:0] word_one = list_mem[word_index(pointer + `HEADER_BYTES)];
  wire [31:0] word_two = list_mem[word_index(pointer + `HEADER_BYTES + `POINTER_BYTES)];
  wire is_long;
  wire is_short;
  wire is_page;
  wire is_attr;
  wire is_ignore;
  wire is_last;
  wire [31:0] tag_bytes;
  wire [31:0] page_count;
  wire [31:0] page_end;

  element_classifier u_classifier (
    .i_flags(head[`FLAG_MSB:`FLAG_LSB]),
    .o_is_long(is_long),
    .o_is_short(is_short),
    .o_is_page(is_page),
    .o_is_attr(is_attr),
    .o_is_ignore(is_ignore),
    .o_last(is_last),
    .o_tag_bytes(tag_bytes)
  );

  // Page values come from the latched element so the last base can be fetched
  wire [31:0] last_base_addr = page_first + `HEADER_BYTES + page_tag +
    ((page_count - 32'h0000_0001) << 2);
  wire [31:0] last_base = (page_count == 32'h0000_0001) ? page_first :
    list_mem[word_index(last_base_addr)];

  page_span_calc u_span (
    .i_first_pointer(list_mem[word_index(page_first + `HEADER_BYTES + page_tag)]),
    .i_total_octets(page_total),
    .i_page_size(eff_page),
    .i_last_base(last_base),
    .o_page_count(page_count),
    .o_data_end(page_end)
  );

  // Word-count lengths and the page element byte size; ignore, short and attribute share the byte-wide field
  wire [31:0] short_words = {24'h00_0000, head[`WLEN_MSB:`WLEN_LSB]};
  wire [31:0] long_words = {8'h00, head[`TOTAL_MSB:0]};
  wire [31:0] page_bytes = (page_count << 2) + page_tag + `HEADER_BYTES;

  // ****************************************
  // Walk engine
  // ****************************************
  reg [3:0] next_state;
  reg [31:0] next_advance;
  reg [6:0] next_error;
  always @*
  begin
    next_state = state;
    next_advance = 32'h0000_0000;
    next_error = 7'h00;
    case (state)
      S_IDLE:
      begin
        if (start)
          next_state = S_HEAD;
      end
      S_HEAD:
      begin
        if (!in_window(pointer))
          next_error[`ST_ERR_OVERRUN] = 1'b1;
        else if (is_ignore)
          next_advance = short_words << 2;
        else if (is_attr)
        begin
          if (!only_ignored)
            next_error[`ST_ERR_ATTR_POS] = 1'b1;
          if (word_one[`PROP_ADDR_WIDTH])
            next_error[`ST_ERR_ADDR_WIDTH] = 1'b1;
          next_advance = short_words << 2;
        end
        else if (is_long)
          next_advance = long_words << 2;
        else if (is_short)
          next_advance = short_words << 2;
        else if (is_page)
          next_state = S_PAGE;
        else
          next_error[`ST_ERR_KIND] = 1'b1;
        if ((is_ignore | is_attr | is_short) && short_words == 32'h0000_0000)
          next_error[`ST_ERR_LENGTH] = 1'b1;
        if (is_long && long_words == 32'h0000_0000)
          next_error[`ST_ERR_LENGTH] = 1'b1;
        if (next_error != 7'h00 || (is_last && !is_page))
          next_state = S_DONE;
      end
      S_PAGE:
      begin
        next_advance = page_bytes;
        next_state = page_last ? S_DONE : S_HEAD;
      end
      S_DONE:
      begin
        next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Sequencing, results and the list pointer
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state <= S_IDLE;
      pointer <= 32'h0000_0000;
      status <= 7'h00;
      elem_count <= 32'h0000_0000;
      tag_low <= 32'h0000_0000;
      tag_high <= 32'h0000_0000;
      data_end <= 32'h0000_0000;
      eff_page <= `RESET_PAGE_SIZE;
      eff_attr <= 16'h0000;
      only_ignored <= 1'b1;
      page_first <= 32'h0000_0000;
      page_total <= 32'h0000_0000;
      page_tag <= 32'h0000_0000;
      page_last <= 1'b0;
      o_element_strobe <= 1'b0;
      o_element_flags <= 8'h00;
    end
    else
    begin
      state <= next_state;
      o_element_strobe <= 1'b0;
      pointer <= pointer + ((next_advance + 32'h0000_0003) & 32'hFFFF_FFFC);
      status <= status | next_error;
      if (state == S_IDLE && start)
      begin
        pointer <= 32'h0000_0000;
        status <= 7'h01;
        elem_count <= 32'h0000_0000;
        eff_page <= default_page;
        eff_attr <= default_attr[15:0];
        only_ignored <= 1'b1;
      end
      if (state == S_HEAD && next_error == 7'h00 && in_window(pointer))
      begin
        o_element_strobe <= 1'b1;
        o_element_flags <= head[`FLAG_MSB:`FLAG_LSB];
        elem_count <= elem_count + 32'h0000_0001;
        if (!is_ignore)
          only_ignored <= 1'b0;
        if (is_attr)
        begin
          eff_page <= word_two;
          eff_attr <= word_one[15:0] & 16'h0705;
        end
        if (is_long && tag_bytes != 32'h0000_0000)
        begin
          tag_low <= word_one;
          tag_high <= eff_attr[`PROP_CTX64] ? word_two : 32'h0000_0000;
        end
        if (is_page)
        begin
          page_first <= pointer;
          page_total <= {8'h00, head[`TOTAL_MSB:0]};
          page_tag <= tag_bytes;
          page_last <= is_last;
        end
      end
      if (state == S_PAGE)
        data_end <= page_end;
      if (state == S_DONE)
        status <= (status & 7'h7E) | 7'h02;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Answer every access one cycle later; unmapped reads give zero
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      default_page <= `RESET_PAGE_SIZE;
      default_attr <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= bus_req;
      o_wb_dat <= 32'h0000_0000;
      if (bus_req && !i_wb_we)
      begin
        if (mem_hit)
          o_wb_dat <= list_mem[bus_index];
        else if (i_wb_adr == `REG_STATUS)
          o_wb_dat <= {25'h000_0000, status};
        else if (i_wb_adr == `REG_DEFAULT_PAGE)
          o_wb_dat <= default_page;
        else if (i_wb_adr == `REG_DEFAULT_ATTR)
          o_wb_dat <= default_attr;
        else if (i_wb_adr == `REG_ELEM_COUNT)
          o_wb_dat <= elem_count;
        else if (i_wb_adr == `REG_TAG_LOW)
          o_wb_dat <= tag_low;
        else if (i_wb_adr == `REG_TAG_HIGH)
          o_wb_dat <= tag_high;
        else if (i_wb_adr == `REG_DATA_END)
          o_wb_dat <= data_end;
        else if (i_wb_adr == `REG_EFF_PAGE)
          o_wb_dat <= eff_page;
        else if (i_wb_adr == `REG_EFF_ATTR)
          o_wb_dat <= {16'h0000, eff_attr};
      end
      if (bus_write && i_wb_adr == `REG_DEFAULT_PAGE)
        default_page <= lane_merge(default_page, i_wb_dat, i_wb_sel);
      else if (bus_write && i_wb_adr == `REG_DEFAULT_ATTR)
        default_attr <= lane_merge(default_attr, i_wb_dat, i_wb_sel);
    end
  end

  // List window writes; locked while a walk runs so the list stays stable
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      for (i = 0; i < `LIST_WORDS; i = i + 1)
        list_mem[i] <= 32'h0000_0000;
    end
    else if (bus_write && mem_hit && !status[`ST_BUSY])
      list_mem[bus_index] <= lane_merge(list_mem[bus_index], i_wb_dat, i_wb_sel);
  end
endmodule // sgl_element_decoder

/* File: shared/sgl_decoder_defines.vh */
// Purpose: Constants shared by the gather-list element decoder files
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SGL_DECODER_DEFINES_VH
`define SGL_DECODER_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_DEFAULT_PAGE 8'h08
`define REG_DEFAULT_ATTR 8'h0C
`define REG_ELEM_COUNT 8'h10
`define REG_TAG_LOW 8'h14
`define REG_TAG_HIGH 8'h18
`define REG_DATA_END 8'h1C
`define REG_EFF_PAGE 8'h20
`define REG_EFF_ATTR 8'h24
`define REG_LIST_BASE 8'h80
// ****************************************
// List memory and field layout
// ****************************************
`define LIST_WORDS 32
`define LIST_INDEX_BITS 5
`define FLAG_MSB 31
`define FLAG_LSB 24
`define LAST_BIT 31
`define WLEN_MSB 23
`define WLEN_LSB 16
`define TOTAL_MSB 23
`define CODE_LONG 5'h10
`define CODE_SHORT 5'h1C
`define CODE_PAGE 2'h2
`define CODE_ATTR 7'h7C
`define CODE_IGNORE 7'h7F
`define PROP_CTX64 2
`define PROP_ADDR_WIDTH 0
`define HEADER_BYTES 32'h0000_0004
`define POINTER_BYTES 32'h0000_0004
`define RESET_PAGE_SIZE 32'h0000_1000
// ****************************************
// Status bit positions
// ****************************************
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERR_KIND 2
`define ST_ERR_ATTR_POS 3
`define ST_ERR_ADDR_WIDTH 4
`define ST_ERR_LENGTH 5
`define ST_ERR_OVERRUN 6
`endif

/* File: sim/list_builder.sv */
// Purpose: Host side builder of gather lists
// Assumes: Caller has seeded the random source
// Notes: Image is copied into the list window by the bench
`timescale 1ns/100ps
module list_builder;
  logic [31:0] img [0:31];
  int cnt = 0;
  // Append one list word
  task automatic put(input logic [31:0] w);
    begin
      img[cnt] = w;
      cnt++;
    end
  endtask
  // Page element over two to four pages; returns its data end
  task automatic pages(input logic [7:0] fl, input logic [31:0] p, output logic [31:0] fin);
    int n;
    logic [31:0] off;
    logic [31:0] rem;
    logic [31:0] base;
    begin
      n = 2 + $urandom % 3;
      off = $urandom % p;
      rem = 1 + $urandom % p;
      // p is always a power of two of 256 or more
      put({fl, 24'(p - off + (n - 2) * p + rem)});
      for (int k = 0; k < fl[1:0]; k++)
        put($urandom);
      for (int k = 0; k < n; k++)
      begin
        base = $urandom & ~(p - 1);
        // only the first pointer carries an offset
        put(k == 0 ? base + off : base);
      end
      fin = base + rem;
    end
  endtask
endmodule // list_builder

/* File: sim/sgl_decoder_checker_assertions.sv */
// Purpose: Concurrent checks on the decoder's ports
// Assumes: One clock, synchronous active-low reset
// Notes: Watches the bus request and the design-driven outputs
`timescale 1ns/100ps
module sgl_decoder_checker (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Bus request
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  // Design outputs
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire o_busy,
  input wire o_element_strobe,
  input wire [7:0] o_element_flags
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] busy_cnt;
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire start = take && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0] && i_wb_dat[0];
  // Busy run length; a walk longer than the window means a hang
  always @(posedge i_clock)
  begin
    if (!i_rst_n || !o_busy)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= busy_cnt + 8'h01;
  end
  chk_ack_answers: assert property (take |=> o_wb_ack)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (o_wb_ack |-> $past(take))
    else $error("ack without request");
  chk_data_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  chk_start_busy: assert property (start && !o_busy |-> ##[1:2] o_busy)
    else $error("start did not set busy");
  chk_flags_strobe: assert property (!$stable(o_element_flags) |-> o_element_strobe)
    else $error("flags changed without strobe");
  chk_last_stops: assert property (o_element_strobe && o_element_flags[7] |-> ##[0:3] !o_busy)
    else $error("walk went on past last element");
  chk_idle_quiet: assert property (!o_busy && !$past(o_busy) && !$past(o_busy, 2) |-> !o_element_strobe)
    else $error("strobe while idle");
  chk_walk_bound: assert property (busy_cnt <= 8'h46)
    else $error("walk longer than the window");
  cov_long: cover property (o_element_strobe && o_element_flags[6:2] == 5'h10);
  cov_page: cover property (o_element_strobe && o_element_flags[6:4] == 3'h2);
  cov_done: cover property ($fell(o_busy));
endmodule // sgl_decoder_checker

bind sgl_element_decoder sgl_decoder_checker i_sgl_decoder_checker (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_busy(o_busy),
  .o_element_strobe(o_element_strobe), .o_element_flags(o_element_flags));

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the gather-list decoder
// Assumes: Classic Wishbone single cycles, one clock
// Notes: Lists come from the list_builder partner
`timescale 1ns/100ps
`include "sgl_decoder_defines.vh"
module testbench;
  logic i_clock;
  logic i_rst_n;
  logic cyc, stb, we;
  logic [3:0] sel;
  logic [7:0] adr, fl;
  logic [31:0] wdat, rd, p, tag, tag2, exp_end;
  wire [31:0] o_wb_dat;
  wire o_wb_ack, o_busy, o_element_strobe;
  wire [7:0] o_element_flags;
  int error_cnt, samples_checked;
  logic [31:0] tbl [0:11] = '{32'h4000_0001, 32'hFC03_0000, 32'h0, 32'h1000, 32'hFC03_0000, 32'h1,
    32'h1000, 32'h8800_0000, 32'hF000_0000, 32'h7F20_0000, 32'hF102_0000, 32'h1234_5678};
  int cut [0:6] = '{0, 4, 7, 8, 9, 10, 12};
  logic [31:0] sts [0:5] = '{32'h0A, 32'h12, 32'h06, 32'h22, 32'h42, 32'h02};

  sgl_element_decoder i_sgl_element_decoder (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_busy(o_busy), .o_element_strobe(o_element_strobe),
    .o_element_flags(o_element_flags));
  list_builder i_list_builder ();

  // Free-running 100 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Verdict and end of run
  task automatic wrap_up();
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Compare one 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge i_clock);
      while (o_wb_ack !== 1'b1 && n < 20)
      begin
        n++;
        @(posedge i_clock);
      end
      rd = o_wb_dat;
      chk({31'h0, o_wb_ack}, 32'h1, "ack");
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_clock);
    end
  endtask

  // Load the built list, start the walk, poll until done
  task automatic run(input logic [31:0] st, input logic [7:0] f);
    int n;
    begin
      n = 0;
      for (int k = 0; k < i_list_builder.cnt; k++)
        wb(1'b1, 8'h80 + 8'(4 * k), i_list_builder.img[k]);
      wb(1'b1, `REG_CONTROL, 32'h1);
      rd = 32'h0;
      while (rd[`ST_DONE] !== 1'b1 && n < 50)
      begin
        wb(1'b0, `REG_STATUS, 32'h0);
        n++;
      end
      chk(rd, st, "status");
      if (f != 8'h00)
        chk({24'h0, o_element_flags}, {24'h0, f}, "flags");
      i_list_builder.cnt = 0;
    end
  endtask

  // Watchdog: the run needs well under a thousand cycles, 20000 is ample
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    i_rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    error_cnt = 0;
    samples_checked = 0;
    p = $urandom(32'hCD48C54D);
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wb(1'b0, `REG_DEFAULT_PAGE, 32'h0);
    chk(rd, `RESET_PAGE_SIZE, "default page");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
    // Byte lanes: only lane 1 of the default page may change, result stays a power of two
    sel <= 4'h2;
    wb(1'b1, `REG_DEFAULT_PAGE, 32'hFFFF_20FF);
    sel <= 4'hF;
    wb(1'b0, `REG_DEFAULT_PAGE, 32'h0);
    chk(rd, 32'h0000_2000, "lane merge");
    // Ignore, attribute, long element with 64-bit tag, then pages
    tag = $urandom;
    tag2 = $urandom;
    wb(1'b1, `REG_DEFAULT_PAGE, 32'h100);
    i_list_builder.put(32'h7F01_0000);
    i_list_builder.put(32'h7C03_0000);
    i_list_builder.put(32'h0000_FFFE);
    i_list_builder.put(32'h0000_2000);
    i_list_builder.put(32'h4200_0003);
    i_list_builder.put(tag);
    i_list_builder.put(tag2);
    i_list_builder.pages(8'hA0, 32'h2000, exp_end);
    run(32'h2, 8'hA0);
    wb(1'b0, `REG_EFF_PAGE, 32'h0);
    chk(rd, 32'h2000, "frame size");
    wb(1'b0, `REG_EFF_ATTR, 32'h0);
    chk(rd, 32'h0704, "properties");
    wb(1'b0, `REG_TAG_LOW, 32'h0);
    chk(rd, tag, "tag low");
    wb(1'b0, `REG_TAG_HIGH, 32'h0);
    chk(rd, tag2, "tag high");
    wb(1'b0, `REG_DATA_END, 32'h0);
    chk(rd, exp_end, "data end");
    // Random page lists under node defaults (64-bit context), a short element after each
    wb(1'b1, `REG_DEFAULT_ATTR, 32'h4);
    for (int t = 0; t < 6; t++)
    begin
      p = 32'h100 << ($urandom % 5);
      fl = 8'h20 | 8'($urandom % 16);
      wb(1'b1, `REG_DEFAULT_PAGE, p);
      i_list_builder.pages(fl, p, exp_end);
      i_list_builder.put(32'hF001_0000);
      run(32'h2, 8'hF0);
      wb(1'b0, `REG_EFF_PAGE, 32'h0);
      chk(rd, p, "default page used");
      wb(1'b0, `REG_EFF_ATTR, 32'h0);
      chk(rd, 32'h4, "default properties");
      wb(1'b0, `REG_DATA_END, 32'h0);
      chk(rd, exp_end, "data end");
    end
    // Faulty and corner lists from the table
    for (int c = 0; c < 6; c++)
    begin
      for (int k = cut[c]; k < cut[c + 1]; k++)
        i_list_builder.put(tbl[k]);
      run(sts[c], c == 5 ? 8'hF1 : 8'h00);
    end
    wrap_up();
  end
endmodule // testbench
